//--- rtl/fault_response_supervisor.v
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
// What this block does
// - motor overcurrent accepted only after persisting about one microsecond
// - flags latch only when latch enable bit is one, else follow condition
// - filtered overcurrent pulls fault pin low when its pin enable is one
// - filtered overcurrent stops pre-drivers when its shutdown enable is one
// - overcurrent threshold field drives the analog reference select
// - sense zero-offset field selects 0.5, 1 or 1.5 volt level
// - battery undervoltage always stops pre-drivers while present
// - battery overvoltage stops pre-drivers when selected or when its shutdown enable is one
// - pre-drivers resume alone once battery condition disappears
// - battery undervoltage threshold field has four settings
// - main regulator undervoltage threshold is selectable
// - over-temperature sets thermal flag, stops pre-drivers when its shutdown enable is one
// - all logic runs on primary clock; check oscillator only monitors
// - each flagged fault sets its flag, stops drivers, pulls fault low
// - main regulator undervoltage asserts reset, stops drivers, no flag
// - internal regulator undervoltage asserts reset, stops drivers, no flag
// - clock monitor failure asserts reset only
// - flagged faults other than the battery ones stop drivers only with matching shutdown enable
// - flagged faults pull fault pin only with matching pin enable
// - regulator undervoltage shutdown ignores all configuration
// - serial format error only sets error bit in serial output
`include "fault_supervisor_defines.vh"
module fault_response_supervisor #(
    parameter CLOCK_MHZ    = `CLOCK_MHZ,
    parameter CHECK_WINDOW = 16,
    parameter CHECK_MIN    = 4
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    // register port
    input  wire [3:0]  reg_addr_i,
    input  wire [15:0] reg_wdata_i,
    input  wire        reg_write_i,
    input  wire        reg_read_i,
    output reg  [15:0] reg_rdata_o,
    // analog condition pins
    input  wire        battery_overvoltage_i,
    input  wire        battery_undervoltage_i,
    input  wire        pump_overvoltage_i,
    input  wire        pump_undervoltage_i,
    input  wire        main_reg_overvoltage_i,
    input  wire        main_reg_overcurrent_i,
    input  wire        motor_overcurrent_i,
    input  wire        internal_reg_overvoltage_i,
    input  wire        thermal_shutdown_i,
    input  wire        main_reg_undervoltage_i,
    input  wire        internal_reg_undervoltage_i,
    input  wire        serial_format_error_i,
    input  wire        check_oscillator_i,
    // responses
    output reg         predriver_enable_o,
    output reg         fault_n_o,
    output reg         mcu_reset_n_o,
    output reg         serial_error_bit_o,
    output reg  [2:0]  overcurrent_ref_level_o,
    output reg  [1:0]  sense_zero_offset_o,
    output reg  [1:0]  battery_uv_threshold_sel_o,
    output reg         main_reg_uv_threshold_sel_o
);
    // filter length: least time rounds up to whole cycles
    localparam integer OC_CYCLES_RAW = (`OC_FILTER_NS * CLOCK_MHZ + 999) / 1000;
    localparam integer OC_CYCLES     = (OC_CYCLES_RAW < 1) ? 1 : OC_CYCLES_RAW;
    localparam integer OC_LAST_INT   = OC_CYCLES - 1;
    localparam [5:0]   OC_LAST       = OC_LAST_INT[5:0];
    localparam [1:0]   ST_RUN        = 2'h0;
    localparam [1:0]   ST_STOP       = 2'h1;
    localparam [1:0]   ST_RESET      = 2'h2;

    // decode a register address, used by the write paths
    function hit;
        input [3:0] addr;
        input [3:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // synchronised pins and named views of them
    wire [12:0] raw_sync;
    wire        check_clk_sync;
    wire        main_uv_sync;
    wire        int_uv_sync;
    wire        fmt_err_sync;

    // software-visible configuration
    reg  [7:0]  fault_config_ff;
    reg  [7:0]  sense_config_ff;
    reg  [8:0]  shutdown_enables_ff;
    reg  [8:0]  fault_pin_enables_ff;

    // flag state
    reg  [8:0]  fault_flags_ff;
    wire [8:0]  nxt_fault_flags;
    wire        latch_mode;
    wire        flag_clear;
    genvar      g;

    // overcurrent filter
    reg  [5:0]  oc_count_ff;
    reg         oc_filtered_ff;

    // clock monitor
    reg         check_prev_ff;
    reg  [7:0]  win_count_ff;
    reg  [7:0]  edge_count_ff;
    reg         clock_fail_ff;
    wire        check_rise;
    wire        window_end;

    // driver state and combined conditions
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    wire [8:0]  live;
    wire        flag_stop;
    wire        flag_pin;
    wire        reg_uv;
    wire        batt_stop;

    // condition pins pass two flip-flops before any logic
    pin_sync #(
        .WIDTH (13)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({check_oscillator_i, serial_format_error_i,
                   internal_reg_undervoltage_i, main_reg_undervoltage_i,
                   thermal_shutdown_i, internal_reg_overvoltage_i,
                   motor_overcurrent_i, main_reg_overcurrent_i,
                   main_reg_overvoltage_i, pump_undervoltage_i,
                   pump_overvoltage_i, battery_undervoltage_i,
                   battery_overvoltage_i}),
        .sync_o  (raw_sync)
    );
    assign check_clk_sync = raw_sync[12];
    // pins that bypass the flag vector
    assign main_uv_sync   = raw_sync[9];
    assign int_uv_sync    = raw_sync[10];
    assign fmt_err_sync   = raw_sync[11];

    // overcurrent persistence counter
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oc_count_ff    <= 6'h00;
            oc_filtered_ff <= 1'b0;
        end else if (!raw_sync[`FLG_MOTOR_OC]) begin
            oc_count_ff    <= 6'h00;
            oc_filtered_ff <= 1'b0;
        end else if (oc_count_ff == OC_LAST) begin
            oc_filtered_ff <= 1'b1;
        end else begin
            oc_count_ff    <= oc_count_ff + 6'h01;
        end
    end

    // live condition vector, overcurrent taken after the filter
    assign live = {raw_sync[8], raw_sync[7], oc_filtered_ff, raw_sync[5:0]};

    // latch mode and the write-one-to-clear strobe
    assign latch_mode = fault_config_ff[`FC_LATCH_BIT];
    assign flag_clear = reg_write_i & hit(reg_addr_i, `ADDR_FAULT_FLAGS);

    // one cell per flag: follow live, or hold until cleared; a live event wins
    generate
        for (g = 0; g < `NUM_FLAGS; g = g + 1) begin : flag_cell
            assign nxt_fault_flags[g] = live[g]
                                      | (latch_mode & fault_flags_ff[g]
                                         & ~(flag_clear & reg_wdata_i[g]));
        end
    endgenerate

    // flag register
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_flags_ff <= 9'h000;
        end else begin
            fault_flags_ff <= nxt_fault_flags;
        end
    end

    // configuration registers
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_config_ff      <= `RST_FAULT_CONFIG;
            sense_config_ff      <= `RST_SENSE_CONFIG;
            shutdown_enables_ff  <= `RST_SHUTDOWN_EN;
            fault_pin_enables_ff <= `RST_FAULT_PIN_EN;
        end else if (reg_write_i) begin
            if (hit(reg_addr_i, `ADDR_FAULT_CONFIG)) begin
                fault_config_ff <= reg_wdata_i[7:0];
            end
            if (hit(reg_addr_i, `ADDR_SENSE_CONFIG)) begin
                sense_config_ff <= reg_wdata_i[7:0];
            end
            if (hit(reg_addr_i, `ADDR_SHUTDOWN_EN)) begin
                shutdown_enables_ff <= reg_wdata_i[8:0];
            end
            if (hit(reg_addr_i, `ADDR_FAULT_PIN_EN)) begin
                fault_pin_enables_ff <= reg_wdata_i[8:0];
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `ADDR_FAULT_CONFIG: begin
                    reg_rdata_o <= {8'h00, fault_config_ff};
                end
                `ADDR_SENSE_CONFIG: begin
                    reg_rdata_o <= {8'h00, sense_config_ff};
                end
                `ADDR_SHUTDOWN_EN: begin
                    reg_rdata_o <= {7'h00, shutdown_enables_ff};
                end
                `ADDR_FAULT_PIN_EN: begin
                    reg_rdata_o <= {7'h00, fault_pin_enables_ff};
                end
                `ADDR_FAULT_FLAGS: begin
                    reg_rdata_o <= {7'h00, fault_flags_ff};
                end
                `ADDR_LIVE_STATUS: begin
                    reg_rdata_o <= {8'h00, state_ff, clock_fail_ff, fmt_err_sync, int_uv_sync,
                                    predriver_enable_o, fault_n_o, mcu_reset_n_o};
                end
                default: begin
                    reg_rdata_o <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // rising edge of the synchronised check clock and the window boundary
    assign check_rise = check_clk_sync & ~check_prev_ff;
    assign window_end = (win_count_ff == CHECK_WINDOW[7:0] - 8'h01);

    // clock monitor: count check-clock edges in a window of primary cycles
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            check_prev_ff <= 1'b0;
            win_count_ff  <= 8'h00;
            edge_count_ff <= 8'h00;
            clock_fail_ff <= 1'b0;
        end else begin
            check_prev_ff <= check_clk_sync;
            if (window_end) begin
                win_count_ff  <= 8'h00;
                edge_count_ff <= 8'h00;
                clock_fail_ff <= (edge_count_ff < CHECK_MIN[7:0]);
            end else begin
                win_count_ff <= win_count_ff + 8'h01;
                if (check_rise && edge_count_ff != 8'hff) begin
                    edge_count_ff <= edge_count_ff + 8'h01;
                end
            end
        end
    end

    // flagged faults gated by their enables
    assign flag_stop = |(live & shutdown_enables_ff);
    assign flag_pin  = |(live & fault_pin_enables_ff);
    // battery undervoltage needs no enable, overvoltage needs selection
    assign batt_stop = live[`FLG_BATT_UV]
                     | (live[`FLG_BATT_OV] & fault_config_ff[`FC_BATTERY_OVERVOLTAGE_SD_BIT]);
    // regulator undervoltage ignores all configuration
    assign reg_uv    = main_uv_sync | int_uv_sync;

    // driver state: run, stopped by fault, stopped under reset
    always @* begin
        nxt_state = ST_RUN;
        if (reg_uv) begin
            nxt_state = ST_RESET;
        end else if (flag_stop || batt_stop) begin
            nxt_state = ST_STOP;
        end
    end

    // driver state register, read back in the live status word
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // pre-driver enable follows the next driver state
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            predriver_enable_o <= 1'b0;
        end else begin
            case (nxt_state)
                ST_RUN: begin
                    predriver_enable_o <= 1'b1;
                end
                ST_STOP: begin
                    predriver_enable_o <= 1'b0;
                end
                ST_RESET: begin
                    predriver_enable_o <= 1'b0;
                end
                default: begin
                    predriver_enable_o <= 1'b0;
                end
            endcase
        end
    end

    // fault pin, reset output and serial error bit
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_n_o          <= 1'b1;
            mcu_reset_n_o      <= 1'b0;
            serial_error_bit_o <= 1'b0;
        end else begin
            fault_n_o          <= ~flag_pin;
            mcu_reset_n_o      <= ~(reg_uv | clock_fail_ff);
            serial_error_bit_o <= fmt_err_sync;
        end
    end

    // analog selects mirror the configuration fields
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overcurrent_ref_level_o     <= 3'h0;
            sense_zero_offset_o         <= 2'h0;
            battery_uv_threshold_sel_o  <= 2'h0;
            main_reg_uv_threshold_sel_o <= 1'b0;
        end else begin
            overcurrent_ref_level_o <= fault_config_ff[`FC_OCTH_HI:`FC_OCTH_LO];
            // code 3 is not a level, fall back to the lowest offset
            sense_zero_offset_o <= (sense_config_ff[`SC_OFS_HI:`SC_OFS_LO] == 2'h3) ?
                                   2'h0 : sense_config_ff[`SC_OFS_HI:`SC_OFS_LO];
            battery_uv_threshold_sel_o <= fault_config_ff[`FC_BATTERY_UNDERVOLTAGE_HI:`FC_BATTERY_UNDERVOLTAGE_LO];
            main_reg_uv_threshold_sel_o <= fault_config_ff[`FC_VCCUV_BIT];
        end
    end
endmodule

//--- rtl/fault_supervisor_defines.vh
`ifndef FAULT_SUPERVISOR_DEFINES_VH
`define FAULT_SUPERVISOR_DEFINES_VH

// register offsets
`define ADDR_FAULT_CONFIG    4'h0
`define ADDR_SENSE_CONFIG    4'h1
`define ADDR_SHUTDOWN_EN     4'h2
`define ADDR_FAULT_PIN_EN    4'h3
`define ADDR_FAULT_FLAGS     4'h4
`define ADDR_LIVE_STATUS     4'h5

// fault_config fields
`define FC_LATCH_BIT         0
`define FC_BATTERY_OVERVOLTAGE_SD_BIT       1
`define FC_BATTERY_UNDERVOLTAGE_LO           2
`define FC_BATTERY_UNDERVOLTAGE_HI           3
`define FC_VCCUV_BIT         4
`define FC_OCTH_LO           5
`define FC_OCTH_HI           7

// sense_config fields
`define SC_OFS_LO            0
`define SC_OFS_HI            1

// fault flag bit positions
`define FLG_BATT_OV          0
`define FLG_BATT_UV          1
`define FLG_PUMP_OV          2
`define FLG_PUMP_UV          3
`define FLG_MAIN_OV          4
`define FLG_MAIN_OC          5
`define FLG_MOTOR_OC         6
`define FLG_INT_OV           7
`define FLG_THERMAL          8
`define NUM_FLAGS            9

// reset values
`define RST_FAULT_CONFIG     8'h00
`define RST_SENSE_CONFIG     8'h00
`define RST_SHUTDOWN_EN      9'h1ff
`define RST_FAULT_PIN_EN     9'h1ff

// timing: overcurrent filter time in ns
`define OC_FILTER_NS         1000
`define CLOCK_MHZ            25

`endif

//--- rtl/pin_sync.v
`timescale 1ns/100ps
// two-stage synchroniser for a vector of pin levels
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clock_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    // first stage feeds only the second
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_o = stage2_ff;
endmodule

//--- verification/fault_response_supervisor_tb_top.sv
`timescale 1ns/100ps
`include "fault_supervisor_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module fault_response_supervisor_tb_top;
    reg         clock_i;
    reg         rst_n_i;
    reg  [11:0] cond_ff;
    reg         osc_ff = 1'b0;
    reg         osc_run;
    reg  [15:0] d;
    wire [3:0]  addr;
    wire [15:0] wdata;
    wire [15:0] rdata;
    wire        wr_stb;
    wire        rd_stb;
    wire        drv;
    wire        fault_n;
    wire        res_n;
    wire        ser_err;
    wire [2:0]  oc_ref;
    wire [1:0]  ofs;
    wire [1:0]  buv_sel;
    wire        muv_sel;
    integer     n_errors;
    integer     n_tests;
    integer     i;
    integer     p;
    mcu_bus_model mcu (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .write_o(wr_stb), .read_o(rd_stb));
    fault_response_supervisor dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr_stb), .reg_read_i(rd_stb), .reg_rdata_o(rdata),
        .battery_overvoltage_i(cond_ff[0]), .battery_undervoltage_i(cond_ff[1]),
        .pump_overvoltage_i(cond_ff[2]), .pump_undervoltage_i(cond_ff[3]),
        .main_reg_overvoltage_i(cond_ff[4]), .main_reg_overcurrent_i(cond_ff[5]),
        .motor_overcurrent_i(cond_ff[6]), .internal_reg_overvoltage_i(cond_ff[7]),
        .thermal_shutdown_i(cond_ff[8]), .main_reg_undervoltage_i(cond_ff[9]),
        .internal_reg_undervoltage_i(cond_ff[10]), .serial_format_error_i(cond_ff[11]),
        .check_oscillator_i(osc_ff), .predriver_enable_o(drv), .fault_n_o(fault_n),
        .mcu_reset_n_o(res_n), .serial_error_bit_o(ser_err),
        .overcurrent_ref_level_o(oc_ref), .sense_zero_offset_o(ofs),
        .battery_uv_threshold_sel_o(buv_sel), .main_reg_uv_threshold_sel_o(muv_sel));
    task close_out;
        begin
            if (n_errors == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task hold(input integer n);
        begin
            repeat (n) @(posedge clock_i);
            @(negedge clock_i);
        end
    endtask
    task sc(input integer k, input v);
        begin
            @(posedge clock_i);
            cond_ff[k] <= v;
        end
    endtask
    task rc(input [3:0] a, input [15:0] e);
        begin
            mcu.rd(a, d);
            `CHK(d, e)
        end
    endtask
    // clock, check oscillator and watchdog
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (osc_run) osc_ff <= ~osc_ff;
    end
    initial begin
        repeat (10000) @(posedge clock_i);
        n_errors = n_errors + 1;
        close_out;
    end
    // main sequence
    initial begin
        n_errors = 0;
        n_tests  = 0;
        rst_n_i  = 1'b0;
        cond_ff  = 12'h000;
        osc_run  = 1'b1;
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        hold(2);
        `CHK({drv, fault_n, res_n}, 3'b111)
        rc(`ADDR_SHUTDOWN_EN, 16'h01ff);
        rc(`ADDR_FAULT_PIN_EN, 16'h01ff);
        rc(4'h9, 16'h0000);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 9; i++) begin
                sc(i, 1'b1);
                hold(40);
                `CHK({drv, fault_n, res_n}, {p == 1 && i != 1, p == 1, 1'b1})
                rc(`ADDR_FAULT_FLAGS, 16'h0001 << i);
                sc(i, 1'b0);
                hold(40);
                `CHK({drv, fault_n, res_n}, 3'b111)
            end
            mcu.wr(`ADDR_SHUTDOWN_EN, 16'h0000);
            mcu.wr(`ADDR_FAULT_PIN_EN, 16'h0000);
        end
        mcu.wr(`ADDR_FAULT_CONFIG, 16'h0002);
        sc(0, 1'b1);
        hold(8);
        `CHK(drv, 1'b0)
        sc(0, 1'b0);
        hold(8);
        `CHK(drv, 1'b1)
        for (i = 9; i < 11; i++) begin
            sc(i, 1'b1);
            hold(8);
            `CHK({drv, fault_n, res_n}, 3'b010)
            rc(`ADDR_FAULT_FLAGS, 16'h0000);
            sc(i, 1'b0);
            hold(8);
        end
        sc(11, 1'b1);
        hold(8);
        `CHK({drv, fault_n, res_n, ser_err}, 4'b1111)
        sc(11, 1'b0);
        mcu.wr(`ADDR_SHUTDOWN_EN, 16'h01ff);
        mcu.wr(`ADDR_FAULT_PIN_EN, 16'h01ff);
        for (i = 0; i < 2; i++) begin
            sc(6, 1'b1);
            hold(20);
            `CHK(fault_n, 1'b1)
            sc(6, 1'b0);
        end
        sc(6, 1'b1);
        hold(22);
        `CHK(fault_n, 1'b1)
        hold(12);
        `CHK({drv, fault_n}, 2'b00)
        sc(6, 1'b0);
        hold(8);
        mcu.wr(`ADDR_FAULT_CONFIG, 16'h0001);
        sc(8, 1'b1);
        hold(8);
        sc(8, 1'b0);
        hold(8);
        rc(`ADDR_FAULT_FLAGS, 16'h0100);
        mcu.wr(`ADDR_FAULT_FLAGS, 16'h0100);
        rc(`ADDR_FAULT_FLAGS, 16'h0000);
        for (i = 0; i < 8; i++) begin
            mcu.wr(`ADDR_FAULT_CONFIG, {8'h00, i[2:0], i[0], i[1:0], 2'b00});
            hold(2);
            `CHK({oc_ref, buv_sel, muv_sel}, {i[2:0], i[1:0], i[0]})
        end
        for (i = 0; i < 4; i++) begin
            mcu.wr(`ADDR_SENSE_CONFIG, i[15:0]);
            hold(2);
            `CHK(ofs, (i == 3) ? 2'h0 : i[1:0])
        end
        @(posedge clock_i);
        osc_run <= 1'b0;
        hold(60);
        `CHK({drv, fault_n, res_n}, 3'b110)
        rc(`ADDR_LIVE_STATUS, 16'h0026);
        @(posedge clock_i);
        osc_run <= 1'b1;
        hold(60);
        `CHK(res_n, 1'b1)
        close_out;
    end
endmodule

//--- verification/fault_supervisor_props.sv
`timescale 1ns/100ps
// port-level checks on the supervisor
module fault_supervisor_props (
    input wire        clock_i,
    input wire        rst_n_i,
    input wire [3:0]  reg_addr_i,
    input wire        reg_read_i,
    input wire [15:0] reg_rdata_o,
    input wire        battery_undervoltage_i,
    input wire        main_reg_undervoltage_i,
    input wire        internal_reg_undervoltage_i,
    input wire        serial_format_error_i,
    input wire        check_oscillator_i,
    input wire        predriver_enable_o,
    input wire        mcu_reset_n_o,
    input wire        serial_error_bit_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    reg [5:0] still_ff;
    reg       osc_ff;
    // cycles that the check oscillator has not moved
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            still_ff <= 6'h00;
            osc_ff   <= 1'b0;
        end else begin
            osc_ff   <= check_oscillator_i;
            still_ff <= (check_oscillator_i != osc_ff) ? 6'h00 :
                        (still_ff == 6'h3f) ? still_ff : still_ff + 6'h01;
        end
    end
    a_main_uv_reset: assert property (main_reg_undervoltage_i [*4] |->
        !mcu_reset_n_o && !predriver_enable_o) else $error("main uv not handled");
    a_int_uv_reset: assert property (internal_reg_undervoltage_i [*4] |->
        !mcu_reset_n_o && !predriver_enable_o) else $error("internal uv not handled");
    a_batt_uv_stop: assert property (battery_undervoltage_i [*4] |->
        !predriver_enable_o) else $error("battery uv left drivers on");
    a_fmt_err_set: assert property (serial_format_error_i [*4] |->
        serial_error_bit_o) else $error("format error bit missing");
    a_fmt_err_clear: assert property (!serial_format_error_i [*4] |->
        !serial_error_bit_o) else $error("format error bit stuck");
    a_read_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property ($past(reg_read_i) && $past(reg_addr_i) > 4'h5 |->
        reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_upper_zero: assert property (reg_rdata_o[15:9] == 7'h00)
        else $error("upper read bits set");
    a_clock_fail: assert property (still_ff >= 6'h30 |-> !mcu_reset_n_o)
        else $error("stopped oscillator not caught");
endmodule

bind fault_response_supervisor fault_supervisor_props chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .battery_undervoltage_i(battery_undervoltage_i),
    .main_reg_undervoltage_i(main_reg_undervoltage_i),
    .internal_reg_undervoltage_i(internal_reg_undervoltage_i),
    .serial_format_error_i(serial_format_error_i), .check_oscillator_i(check_oscillator_i),
    .predriver_enable_o(predriver_enable_o), .mcu_reset_n_o(mcu_reset_n_o),
    .serial_error_bit_o(serial_error_bit_o));

//--- verification/mcu_bus_model.sv
`timescale 1ns/100ps
// microcontroller side of the register port
module mcu_bus_model (
    input  wire        clock_i,
    input  wire [15:0] rdata_i,
    output reg  [3:0]  addr_o,
    output reg  [15:0] wdata_o,
    output reg         write_o,
    output reg         read_o
);
    initial begin
        addr_o  = 4'h0;
        wdata_o = 16'h0000;
        write_o = 1'b0;
        read_o  = 1'b0;
    end
    // one-cycle write, data scrambled once released
    task wr(input [3:0] a, input [15:0] v);
        begin
            @(posedge clock_i);
            addr_o  <= a;
            wdata_o <= v;
            write_o <= 1'b1;
            @(posedge clock_i);
            write_o <= 1'b0;
            wdata_o <= ~v;
        end
    endtask
    // one-cycle read, data taken in the following cycle
    task rd(input [3:0] a, output [15:0] v);
        begin
            @(posedge clock_i);
            addr_o <= a;
            read_o <= 1'b1;
            @(posedge clock_i);
            read_o <= 1'b0;
            addr_o <= ~a;
            @(negedge clock_i);
            v = rdata_i;
        end
    endtask
endmodule
